/* watchdog_and_sleep_control.v */
// Watchdog timer, shared scaler and power-down (sleep) control
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ns
`include "guard_sleep_consts.vh"

// Summary of operation
// R01: Guard timer counts edges of its own free-running RC oscillator input.
// R02: Guard time-out in normal running requests a full device reset.
// R03: Guard time-out while sleeping wakes the device without reset.
// R04: A guard time-out clears the active-low timeout flag, unless sleep executes in the same cycle.
// R05: Guard timer is disabled when the configuration enable bit is clear.
// R06: One scaler serves Timer0 or guard timer, selected in timing setup register.
// R07: Clear-guard op and sleep clear guard timer and its assigned postscaler.
// R08: Clear-guard op clears only scaler count, never the assignment bit.
// R09: Sleep clears guard, clears powerdown flag, sets timeout flag, stops oscillator.
// R10: I/O ports hold their pre-sleep drive state during sleep.
// R11: Sleep ends on external reset, guard time-out, or enabled wake interrupts.
// R12: External reset wake resets the device; other wakes continue execution.
// R13: Powerdown flag is set at power-up.
// R14: Only peripheral interrupts needing no on-chip clock may wake.
// R15: Interrupt wake needs the source enable bit, not the global enable.
// R16: After interrupt wake, next instruction runs, then vector if global enable set.
// R17: Next program address is prefetched while sleep executes.
// R18: Sleep with an enabled pending interrupt acts as a no-operation.
// R19: Interrupt during sleep execution completes sleep then wakes at once.
// R20: Crystal modes wait 1024 oscillator periods before resuming; RC mode none.
// R21: Software clears guard before sleep and places a no-op after it.
// R22: Global interrupt enable is bit 7 of interrupt control, cleared on reset.
// R23: Guard base count and scaler ratio decoding are design parameters.
// R24: RC oscillator input is synchronised into the main clock domain before use.
module watchdog_and_sleep_control #(
    parameter IRQ_COUNT        = 14,
    parameter WAKE_CAPABLE     = 14'h3FFF,
    parameter GUARD_CNT_W      = 8,
    parameter GUARD_BASE_COUNT = 8'hFF,
    parameter SCALER_W         = 8
) (
    input  wire                  clk,
    input  wire                  resetn,
    input  wire [`ADDR_W-1:0]    regAddr,
    input  wire [7:0]            regWrData,
    input  wire                  regWr,
    input  wire                  regRd,
    output reg  [7:0]            regRdData,
    input  wire [7:0]            configStrap,
    input  wire                  rcOscIn,
    input  wire                  extResetN,
    input  wire                  guardClearOp,
    input  wire                  sleepOp,
    input  wire [IRQ_COUNT-1:0]  irqFlags,
    input  wire [IRQ_COUNT-1:0]  irqEnables,
    input  wire                  timer0Tick,
    output reg                   timer0Inc,
    output reg                   deviceResetReq,
    output reg                   mainOscEn,
    output reg                   portHold,
    output reg                   sleeping,
    output reg                   prefetchNext,
    output reg                   resumeExec,
    output reg                   branchVector,
    output reg  [12:0]           vectorAddr,
    output reg                   timeoutFlagN,
    output reg                   powerdownFlagN,
    output reg                   globalIrqEnable
);

    // ==================================================
    // States
    localparam [3:0] ST_RUN     = 4'h1;
    localparam [3:0] ST_SLEEP   = 4'h2;
    localparam [3:0] ST_STARTUP = 4'h4;
    localparam [3:0] ST_RESUME  = 4'h8;

    // Last startup count, cut to the counter width
    localparam integer STARTUP_LAST_INT = (`OSC_STARTUP_CYCLES) - 1;
    localparam [`STARTUP_CNT_W-1:0] STARTUP_LAST = STARTUP_LAST_INT[`STARTUP_CNT_W-1:0];

    // ==================================================
    // Scaler limit decoding: guard uses 1:2^n, Timer0 uses 1:2^(n+1)
    function [SCALER_W-1:0] scalerLimit;
        input [2:0] ratio;
        input       forGuard;
        reg   [3:0] shift;
        begin
            shift = forGuard ? {1'b0, ratio} : ({1'b0, ratio} + 4'h1);
            scalerLimit = ((8'h01 << shift) - 8'h01);
        end
    endfunction

    // ==================================================
    // Synchronisers for pin inputs
    reg [1:0] rcSync_q;
    reg       rcLast_q;
    reg [1:0] extRstSync_q;
    reg       extRstLast_q;

    // Reset values match the idle pin levels, so no false edge follows reset
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rcSync_q     <= 2'h0;
            rcLast_q     <= 1'b0;
            extRstSync_q <= 2'h3;
            extRstLast_q <= 1'b1;
        end else begin
            rcSync_q     <= {rcSync_q[0], rcOscIn};       // see R24
            rcLast_q     <= rcSync_q[1];
            extRstSync_q <= {extRstSync_q[0], extResetN};
            extRstLast_q <= extRstSync_q[1];
        end
    end

    wire rcEdge   = rcSync_q[1] & ~rcLast_q;               // see R01
    wire extRstIn = ~extRstSync_q[1];
    wire extRstGo = ~extRstSync_q[1] & extRstLast_q;

    // ==================================================
    // Registers and strap capture
    reg [7:0] timingSetup_q;
    reg [7:0] intControl_q;
    reg [7:0] configWord_q;
    reg       strapTaken_q;
    reg [3:0] state_q;
    reg [3:0] state_d;

    wire guardEnable  = configWord_q[`GUARD_ENABLE_BIT];
    wire scalerGuard  = timingSetup_q[`SCALER_ASSIGN_BIT];
    wire [2:0] ratio  = timingSetup_q[`SCALER_RATIO_HI:`SCALER_RATIO_LO];
    wire rcOscMode    = configWord_q[`OSC_MODE_HI:`OSC_MODE_LO] == `OSC_MODE_RC;

    wire [IRQ_COUNT-1:0] enabledIrq = irqFlags & irqEnables;
    wire irqPending  = |enabledIrq;
    wire irqWake     = |(enabledIrq & WAKE_CAPABLE);       // see R14 R15

    wire inRun       = state_q == ST_RUN;
    // A pending enabled interrupt turns sleep into a no-op
    wire sleepExec   = inRun & sleepOp & ~irqPending;      // see R18
    wire guardClear  = inRun & (guardClearOp | sleepExec); // see R07

    wire selTiming = (regAddr == `TIMING_SETUP_ADDR) | (regAddr == `TIMING_SETUP_ALT);
    wire selIntCtl = regAddr == `INT_CONTROL_ADDR;

    // Configuration word is latched once after power-on reset
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            configWord_q <= `CONFIG_WORD_RST;
            strapTaken_q <= 1'b0;
        end else if (!strapTaken_q) begin
            configWord_q <= configStrap;
            strapTaken_q <= 1'b1;
        end
    end

    // External reset restores the register reset values
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            timingSetup_q <= `TIMING_SETUP_RST;
            intControl_q  <= `INT_CONTROL_RST;            // see R22
        end else if (extRstIn) begin
            timingSetup_q <= `TIMING_SETUP_RST;
            intControl_q  <= `INT_CONTROL_RST;            // see R22
        end else begin
            if (regWr && selTiming) begin
                timingSetup_q <= regWrData;               // see R06
            end
            if (regWr && selIntCtl) begin
                intControl_q <= regWrData;
            end
        end
    end

    // ==================================================
    // Guard timer and shared scaler
    reg [GUARD_CNT_W-1:0] guardCnt_q;
    reg [SCALER_W-1:0]    scalerCnt_q;
    reg                   guardTimeout_q;

    // Base count rolls over on each hit; the postscaler counts base hits
    wire guardBaseHit = rcEdge & (guardCnt_q == GUARD_BASE_COUNT);   // see R23
    wire scalerHit    = scalerCnt_q == scalerLimit(ratio, scalerGuard);
    wire guardFire    = guardBaseHit & (~scalerGuard | scalerHit);

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            guardCnt_q     <= {GUARD_CNT_W{1'b0}};
            scalerCnt_q    <= {SCALER_W{1'b0}};
            guardTimeout_q <= 1'b0;
            timer0Inc      <= 1'b0;
        end else begin
            guardTimeout_q <= 1'b0;
            timer0Inc      <= 1'b0;
            if (!guardEnable || extRstIn || guardClear) begin
                guardCnt_q <= {GUARD_CNT_W{1'b0}};        // see R05 R07
            end else if (rcEdge) begin
                guardCnt_q <= guardBaseHit ? {GUARD_CNT_W{1'b0}} : guardCnt_q + 1'b1;
            end
            // Count only clears, assignment bit stays as written
            if (extRstIn || (guardClear && scalerGuard)) begin
                scalerCnt_q <= {SCALER_W{1'b0}};          // see R08
            end else if (scalerGuard) begin
                if (guardEnable && guardBaseHit) begin
                    scalerCnt_q <= scalerHit ? {SCALER_W{1'b0}} : scalerCnt_q + 1'b1;
                end
            // Timer0 path runs only while the main oscillator runs
            end else if (timer0Tick && mainOscEn) begin
                scalerCnt_q <= scalerHit ? {SCALER_W{1'b0}} : scalerCnt_q + 1'b1;
                timer0Inc   <= scalerHit;                 // see R06
            end
            // A clear in the same cycle as a time-out cancels the time-out
            guardTimeout_q <= guardEnable & ~extRstIn & ~guardClear & guardFire;
        end
    end

    // ==================================================
    // Sleep state machine
    reg [`STARTUP_CNT_W-1:0] startupCnt_q;
    reg                      irqWoke_q;

    always @* begin
        case (state_q)
            ST_RUN: begin
                state_d = sleepExec ? ST_SLEEP : ST_RUN;   // see R09
            end
            ST_SLEEP: begin
                // Wake sources are only looked at while sleeping
                if (guardTimeout_q || irqWake) begin
                    state_d = rcOscMode ? ST_RESUME : ST_STARTUP; // see R11 R19 R20
                end else begin
                    state_d = ST_SLEEP;
                end
            end
            ST_STARTUP: begin
                state_d = (startupCnt_q == STARTUP_LAST) ? ST_RESUME : ST_STARTUP;
            end
            ST_RESUME: begin
                state_d = ST_RUN;
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q      <= ST_RUN;
            startupCnt_q <= {`STARTUP_CNT_W{1'b0}};
            irqWoke_q    <= 1'b0;
        end else if (extRstIn) begin
            state_q      <= ST_RUN;                       // see R12
            startupCnt_q <= {`STARTUP_CNT_W{1'b0}};
            irqWoke_q    <= 1'b0;
        end else begin
            state_q <= state_d;
            // Startup wait counts main clock cycles in crystal modes
            if (state_q == ST_STARTUP) begin
                startupCnt_q <= startupCnt_q + 1'b1;      // see R20
            end else begin
                startupCnt_q <= {`STARTUP_CNT_W{1'b0}};
            end
            if (state_q == ST_SLEEP) begin
                irqWoke_q <= irqWake & ~guardTimeout_q;
            end
        end
    end

    // ==================================================
    // Status flags and core-facing outputs
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            timeoutFlagN    <= 1'b1;
            powerdownFlagN  <= 1'b1;                      // see R13
            deviceResetReq  <= 1'b0;
            mainOscEn       <= 1'b1;
            portHold        <= 1'b0;
            sleeping        <= 1'b0;
            prefetchNext    <= 1'b0;
            resumeExec      <= 1'b0;
            branchVector    <= 1'b0;
            vectorAddr      <= `IRQ_VECTOR;
            globalIrqEnable <= 1'b0;
        end else begin
            prefetchNext    <= sleepExec;                 // see R17
            resumeExec      <= 1'b0;
            branchVector    <= 1'b0;
            deviceResetReq  <= extRstGo;                  // see R12
            globalIrqEnable <= intControl_q[`GLOBAL_IRQ_BIT];
            vectorAddr      <= `IRQ_VECTOR;
            // Sleep sets the timeout flag and wins over a same-cycle time-out
            if (sleepExec) begin
                powerdownFlagN <= 1'b0;                   // see R09
                timeoutFlagN   <= 1'b1;
            end else if (guardTimeout_q && !extRstIn) begin
                timeoutFlagN <= 1'b0;                     // see R04
            end
            // Reset request only while running; in sleep a time-out wakes instead
            if (guardTimeout_q && inRun && !extRstIn) begin
                deviceResetReq <= 1'b1;                   // see R02
            end
            if (extRstIn) begin
                mainOscEn <= 1'b1;
                portHold  <= 1'b0;
                sleeping  <= 1'b0;
            end else begin
                mainOscEn <= ~((state_d == ST_SLEEP) | (state_q == ST_SLEEP));
                portHold  <= (state_d == ST_SLEEP) | (state_d == ST_STARTUP); // see R10
                sleeping  <= state_d == ST_SLEEP;
                if (state_q == ST_RESUME) begin
                    resumeExec   <= 1'b1;                 // see R03 R16
                    branchVector <= irqWoke_q & intControl_q[`GLOBAL_IRQ_BIT];
                end
            end
        end
    end

    // ==================================================
    // Register read port
    // Read data stands one cycle, then returns to zero
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            regRdData <= `RD_UNMAPPED;
        end else if (regRd) begin
            if (selTiming) begin
                regRdData <= timingSetup_q;
            end else if (selIntCtl) begin
                regRdData <= intControl_q;
            end else if (regAddr == `CONFIG_WORD_ADDR) begin
                regRdData <= configWord_q;
            // Status: timeout flag in bit 4, powerdown flag in bit 3
            end else if (regAddr == `STATUS_ADDR) begin
                regRdData <= {3'h0, timeoutFlagN, powerdownFlagN, 3'h0};
            end else begin
                regRdData <= `RD_UNMAPPED;
            end
        end else begin
            regRdData <= `RD_UNMAPPED;
        end
    end

endmodule

/* guard_sleep_consts.vh */
// Constants for the watchdog and sleep control block
`ifndef GUARD_SLEEP_CONSTS_VH
`define GUARD_SLEEP_CONSTS_VH

// ==================================================
// Register map
`define ADDR_W              14
`define TIMING_SETUP_ADDR   14'h0081
`define TIMING_SETUP_ALT    14'h0181
`define CONFIG_WORD_ADDR    14'h2007
`define STATUS_ADDR         14'h0003
`define INT_CONTROL_ADDR    14'h000B
`define RD_UNMAPPED         8'h00

// ==================================================
// Reset values
`define TIMING_SETUP_RST    8'hFF
`define INT_CONTROL_RST     8'h00
`define CONFIG_WORD_RST     8'hFF

// ==================================================
// Field positions
`define SCALER_ASSIGN_BIT   3
`define SCALER_RATIO_HI     2
`define SCALER_RATIO_LO     0
`define GUARD_ENABLE_BIT    2
`define OSC_MODE_HI         1
`define OSC_MODE_LO         0
`define OSC_MODE_RC         2'h3
`define TIMEOUT_FLAG_BIT    4
`define POWERDOWN_FLAG_BIT  3
`define GLOBAL_IRQ_BIT      7

// ==================================================
// Timing
`define MAIN_CLK_NS         10
`define OSC_STARTUP_PERIODS 1024
`define OSC_STARTUP_NS      (`OSC_STARTUP_PERIODS * `MAIN_CLK_NS)
`define OSC_STARTUP_CYCLES  (`OSC_STARTUP_NS / `MAIN_CLK_NS)
`define STARTUP_CNT_W       11
`define IRQ_VECTOR          13'h0004

`endif

/* watchdog_and_sleep_control_assertions.sv */
// Concurrent checks on the watchdog and sleep control ports
`timescale 1ns/1ns
`include "guard_sleep_consts.vh"
module watchdog_and_sleep_control_assertions #(
    parameter IRQ_COUNT = 14
) (
    input wire                 clk,
    input wire                 resetn,
    input wire                 regRd,
    input wire [7:0]           regRdData,
    input wire [7:0]           configStrap,
    input wire                 extResetN,
    input wire                 sleepOp,
    input wire [IRQ_COUNT-1:0] irqFlags,
    input wire [IRQ_COUNT-1:0] irqEnables,
    input wire                 deviceResetReq,
    input wire                 mainOscEn,
    input wire                 portHold,
    input wire                 sleeping,
    input wire                 prefetchNext,
    input wire                 resumeExec,
    input wire                 branchVector,
    input wire [12:0]          vectorAddr,
    input wire                 timeoutFlagN,
    input wire                 powerdownFlagN,
    input wire                 globalIrqEnable
);
    wire pend = |(irqFlags & irqEnables);
    wire inRun = !sleeping && !portHold && extResetN;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    a_sleep_enters: assert property (sleepOp && inRun && !pend |=> sleeping && prefetchNext
        && !powerdownFlagN && timeoutFlagN && !mainOscEn)
        else $error("sleep did not take effect");
    a_sleep_noop: assert property (sleepOp && inRun && pend |=> !sleeping && !prefetchNext
        && $stable(powerdownFlagN) && $stable(timeoutFlagN))
        else $error("sleep with pending irq was not a no-op");
    a_osc_hold: assert property (sleeping |-> !mainOscEn && portHold)
        else $error("oscillator on or ports free while sleeping");
    a_branch_gie: assert property (branchVector |-> resumeExec && globalIrqEnable)
        else $error("vector branch without resume or global enable");
    a_vector_addr: assert property (resumeExec |-> vectorAddr == `IRQ_VECTOR)
        else $error("wrong vector address");
    a_wake_rc: assert property ($fell(sleeping) && configStrap[1:0] == 2'h3 && extResetN
        && $past(extResetN, 4) |=> resumeExec)
        else $error("rc mode wake did not resume at once");
    a_pd_cause: assert property ($fell(powerdownFlagN) |-> $past(sleepOp))
        else $error("powerdown flag cleared without sleep");
    a_prefetch_cause: assert property (prefetchNext |-> $past(sleepOp) && sleeping)
        else $error("prefetch without executed sleep");
    a_reset_pulse: assert property (deviceResetReq |=> !deviceResetReq)
        else $error("reset request longer than one cycle");
    a_ext_reset: assert property ($fell(extResetN) |-> ##[1:4] deviceResetReq)
        else $error("external reset gave no reset request");
    a_read_idle: assert property (!$past(regRd) |-> regRdData == 8'h00)
        else $error("read data outside read slot");
endmodule
bind watchdog_and_sleep_control watchdog_and_sleep_control_assertions #(
    .IRQ_COUNT(IRQ_COUNT)) u_chk (
    .clk(clk), .resetn(resetn), .regRd(regRd), .regRdData(regRdData),
    .configStrap(configStrap), .extResetN(extResetN), .sleepOp(sleepOp),
    .irqFlags(irqFlags), .irqEnables(irqEnables), .deviceResetReq(deviceResetReq),
    .mainOscEn(mainOscEn), .portHold(portHold), .sleeping(sleeping),
    .prefetchNext(prefetchNext), .resumeExec(resumeExec), .branchVector(branchVector),
    .vectorAddr(vectorAddr), .timeoutFlagN(timeoutFlagN),
    .powerdownFlagN(powerdownFlagN), .globalIrqEnable(globalIrqEnable));

/* core_model.sv */
// Core-side model: issues core ops and drives interrupt lines
`timescale 1ns/1ns
module core_model (
    output reg        sleepOp,
    output reg        guardClearOp,
    output reg        timer0Tick,
    output reg [13:0] irqFlags,
    output reg [13:0] irqEnables,
    input  wire       clk
);
    initial begin
        sleepOp = 1'b0;
        guardClearOp = 1'b0;
        timer0Tick = 1'b0;
        irqFlags = 14'h0000;
        irqEnables = 14'h0000;
    end
    // One-cycle op pulse: 0 sleep, 1 guard clear, 2 timer tick
    task pulse(input integer k);
        begin
            @(posedge clk);
            if (k == 0) sleepOp <= 1'b1;
            else if (k == 1) guardClearOp <= 1'b1;
            else timer0Tick <= 1'b1;
            @(posedge clk);
            sleepOp <= 1'b0;
            guardClearOp <= 1'b0;
            timer0Tick <= 1'b0;
        end
    endtask
    task sleepIns;
        begin
            pulse(1);
            pulse(0);
        end
    endtask
    task setIrq(input [13:0] f, input [13:0] e);
        begin
            @(posedge clk);
            irqFlags <= f;
            irqEnables <= e;
        end
    endtask
endmodule

/* watchdog_and_sleep_control_bench.sv */
// Self-checking bench for the watchdog and sleep control block
`timescale 1ns/1ns
`include "guard_sleep_consts.vh"
module watchdog_and_sleep_control_bench;
    reg         clk, resetn, regWr, regRd, rcOscIn, extResetN;
    reg  [13:0] regAddr;
    reg  [7:0]  regWrData, configStrap;
    wire [7:0]  regRdData;
    wire        sleepOp, guardClearOp, timer0Tick, timer0Inc, deviceResetReq, mainOscEn;
    wire        portHold, sleeping, prefetchNext, resumeExec, branchVector;
    wire        timeoutFlagN, powerdownFlagN, globalIrqEnable;
    wire [13:0] irqFlags, irqEnables;
    wire [12:0] vectorAddr;
    integer     error_cnt, n_tests, expTo, expPd, g, n, r;
    integer     rstCnt = 0;
    integer     incCnt = 0;
    watchdog_and_sleep_control #(.GUARD_BASE_COUNT(8'h03)) u_dut (
        .clk(clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .configStrap(configStrap),
        .rcOscIn(rcOscIn), .extResetN(extResetN), .guardClearOp(guardClearOp),
        .sleepOp(sleepOp), .irqFlags(irqFlags), .irqEnables(irqEnables),
        .timer0Tick(timer0Tick), .timer0Inc(timer0Inc), .deviceResetReq(deviceResetReq),
        .mainOscEn(mainOscEn), .portHold(portHold), .sleeping(sleeping),
        .prefetchNext(prefetchNext), .resumeExec(resumeExec), .branchVector(branchVector),
        .vectorAddr(vectorAddr), .timeoutFlagN(timeoutFlagN),
        .powerdownFlagN(powerdownFlagN), .globalIrqEnable(globalIrqEnable));
    core_model u_core (.clk(clk), .sleepOp(sleepOp), .guardClearOp(guardClearOp),
        .timer0Tick(timer0Tick), .irqFlags(irqFlags), .irqEnables(irqEnables));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (deviceResetReq === 1'b1) rstCnt <= rstCnt + 1;
        if (timer0Inc === 1'b1) incCnt <= incCnt + 1;
    end
    task check(input [15:0] seen, input [15:0] exp, input string what);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
                error_cnt = error_cnt + 1;
            end
        end
    endtask
    task finish_test;
        begin
            $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
            if (error_cnt == 0 && n_tests > 0) $display("Test passed");
            else $display("Test failed");
            $finish;
        end
    endtask
    task cyc(input integer k);
        begin
            repeat (k) @(posedge clk);
            #1;
        end
    endtask
    task wr(input [13:0] a, input [7:0] d);
        begin
            @(posedge clk);
            regAddr <= a;
            regWrData <= d;
            regWr <= 1'b1;
            @(posedge clk);
            regWr <= 1'b0;
        end
    endtask
    task rd(input [13:0] a, input [7:0] e);
        begin
            @(posedge clk);
            regAddr <= a;
            regRd <= 1'b1;
            @(posedge clk);
            regRd <= 1'b0;
            #1 check(regRdData, e, "read data");
        end
    endtask
    task rdStatus;
        rd(`STATUS_ADDR, {3'h0, expTo[0], expPd[0], 3'h0});
    endtask
    task rcEdges(input integer k);
        repeat (k) begin
            repeat (3) @(posedge clk);
            rcOscIn <= 1'b1;
            repeat (3) @(posedge clk);
            rcOscIn <= 1'b0;
        end
    endtask
    task waitResume(input integer lim);
        begin
            n = 0;
            while (resumeExec !== 1'b1 && n < lim) begin
                cyc(1);
                n = n + 1;
            end
        end
    endtask
    task doReset(input [7:0] s);
        begin
            @(posedge clk);
            resetn <= 1'b0;
            configStrap <= s;
            repeat (16) @(posedge clk);
            resetn <= 1'b1;
            cyc(2);
            expTo = 1;
            expPd = 1;
        end
    endtask
    initial begin
        #600000;
        error_cnt = error_cnt + 1;
        finish_test;
    end
    initial begin
        {resetn, regWr, regRd, rcOscIn, regAddr, regWrData} = 0;
        extResetN = 1'b1;
        configStrap = 8'hFF;
        {error_cnt, n_tests} = 0;
        r = $urandom(32'hE5B0);
        doReset(8'hFF);
        rdStatus;
        rd(`TIMING_SETUP_ALT, `TIMING_SETUP_RST);
        rd(`INT_CONTROL_ADDR, 8'h00);
        rd(14'h0055, `RD_UNMAPPED);
        wr(`CONFIG_WORD_ADDR, 8'h00);
        rd(`CONFIG_WORD_ADDR, 8'hFF);
        r = $urandom % 3;
        wr(`TIMING_SETUP_ALT, r[7:0]);
        rd(`TIMING_SETUP_ADDR, r[7:0]);
        repeat ((2 << r) * 3) u_core.pulse(2);
        cyc(3);
        check(incCnt, 3, "timer0 increments");
        u_core.setIrq(14'h0001, 14'h0001);
        u_core.sleepIns;
        cyc(2);
        check(sleeping, 0, "sleeping");
        rdStatus;
        for (g = 0; g < 2; g = g + 1) begin
            wr(`INT_CONTROL_ADDR, g[0] ? 8'h80 : 8'h00);
            u_core.setIrq(14'h0000, 14'h0000);
            u_core.sleepIns;
            cyc(1);
            expPd = 0;
            check({sleeping, mainOscEn, portHold}, 3'h5, "sleep outputs");
            rdStatus;
            u_core.setIrq(14'h0020, 14'h0000);
            cyc(10);
            check(sleeping, 1, "sleeping");
            u_core.setIrq(14'h0020, 14'h0020);
            waitResume(20);
            check(branchVector, g, "vector branch");
            check(vectorAddr, `IRQ_VECTOR, "vector address");
            check(globalIrqEnable, g, "global enable");
            u_core.setIrq(14'h0000, 14'h0000);
        end
        wr(`TIMING_SETUP_ADDR, 8'h08);
        repeat (3) begin
            rcEdges(3);
            u_core.pulse(1);
        end
        check(rstCnt, 0, "reset count");
        rd(`TIMING_SETUP_ADDR, 8'h08);
        rcEdges(5);
        cyc(3);
        expTo = 0;
        check(rstCnt, 1, "reset count");
        rdStatus;
        u_core.pulse(1);
        wr(`TIMING_SETUP_ADDR, 8'h09);
        rcEdges(7);
        check(rstCnt, 1, "reset count");
        rcEdges(2);
        cyc(3);
        check(rstCnt, 2, "reset count");
        u_core.sleepIns;
        expTo = 1;
        fork
            rcEdges(8);
            waitResume(100);
        join
        check(n < 100, 1, "guard wake");
        check(branchVector, 0, "vector branch");
        check(rstCnt, 2, "reset count");
        expTo = 0;
        rdStatus;
        u_core.sleepIns;
        @(posedge clk);
        extResetN <= 1'b0;
        cyc(6);
        check({sleeping, rstCnt[3:0]}, 5'h03, "ext reset");
        @(posedge clk);
        extResetN <= 1'b1;
        cyc(4);
        rd(`TIMING_SETUP_ADDR, `TIMING_SETUP_RST);
        rd(`INT_CONTROL_ADDR, 8'h00);
        doReset(8'hF8);
        wr(`TIMING_SETUP_ADDR, 8'h08);
        rcEdges(10);
        cyc(3);
        check(rstCnt, 3, "reset count");
        u_core.sleepIns;
        u_core.setIrq(14'h0002, 14'h0002);
        waitResume(1100);
        check(n >= 1024 && n < 1040, 1, "startup wait");
        finish_test;
    end
endmodule
